// ==== hdl/rrec_pkg.sv ====
// shared constants and types of the rtc rewrite-error and control block
package rrec_pkg;

   // clock rate and the half-second period
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned HALF_SEC_MS  = 500;
   localparam int unsigned HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL1   = 8'h00;
   localparam logic [7:0] OFS_CTRL2   = 8'h04;
   localparam logic [7:0] OFS_SEC_SET = 8'h08;
   localparam logic [7:0] OFS_SEC_VAL = 8'h0c;
   localparam logic [7:0] OFS_STAT    = 8'h10;
   localparam logic [7:0] OFS_MASK    = 8'h14;

   // field positions inside the first control register; the calendar read request bit is in the second
   localparam int unsigned EN_LSB    = 24;
   localparam int unsigned FLAG_LSB  = 16;
   localparam int unsigned ALEN_LSB  = 8;
   localparam int unsigned BUSY_BIT  = 6;
   localparam int unsigned SUBSECOND_COUNTER_RESET_BIT = 5;
   localparam int unsigned ONE_SEC_OUTPUT_STOP_BIT  = 4;
   localparam int unsigned SRST_BIT  = 3;
   localparam int unsigned RUN_BIT   = 2;
   localparam int unsigned ST_BIT    = 0;
   localparam int unsigned CALENDAR_READ_REQUEST_BIT = 0;

   // values after reset and counting limits
   localparam logic [7:0] EVT_RST   = 8'h00;
   localparam logic [4:0] ALEN_RST  = 5'h00;
   localparam logic [5:0] SEC_RST   = 6'h00;
   localparam logic [5:0] SEC_MAX   = 6'h3b;
   localparam logic [1:0] TALLY_RST = 2'h0;
   localparam logic [1:0] TALLY_ERR = 2'h3;

   // one bit per event, most significant first as in the register
   typedef struct packed {
      logic read_done;
      logic rewrite_err;
      logic alarm;
      logic timer;
      logic hour;
      logic minute;
      logic second;
      logic half;
   } rrec_evt_s;

   typedef logic [5:0] rrec_sec_t;

   // seconds rewrite sequence
   typedef enum logic [2:0] {
      RW_COUNT = 3'b001,
      RW_HOLD  = 3'b010,
      RW_LOAD  = 3'b100
   } rrec_rw_e;

endpackage

// ==== hdl/rrec_tick_gen.sv ====
// half-second and one-second carry generator
`timescale 1ns/1ns
`default_nettype none
module rrec_tick_gen #(
   parameter int unsigned HALF_CYCLES = rrec_pkg::HALF_SEC_CYC
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic hold,
   output logic      half_tick,
   output logic      sec_tick
);
   localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic          phase_r;

   // divider held at zero while stopped or under counter reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r   <= '0;
         phase_r <= 1'b0;
      end else if (clk_en) begin
         if (hold) begin
            cnt_r   <= '0;
            phase_r <= 1'b0;
         end else if (cnt_r == LAST) begin
            cnt_r   <= '0;
            phase_r <= ~phase_r;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   // carries are single-cycle pulses; every second half carry is a second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_tick <= 1'b0;
         sec_tick  <= 1'b0;
      end else if (clk_en) begin
         half_tick <= !hold && (cnt_r == LAST);
         sec_tick  <= !hold && (cnt_r == LAST) && phase_r;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/rrec_top.sv ====
// rtc seconds rewrite, rewrite-error detection and first control register
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module rrec_top #(
   parameter int unsigned HALF_CYCLES = rrec_pkg::HALF_SEC_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic        rmw_read,
   input  wire logic        alarm_match_evt,
   input  wire logic        timer_underflow_evt,
   input  wire logic        hour_carry_evt,
   output logic [31:0]      reg_rdata,
   output logic             irq,
   output logic             minute_carry,
   output logic [4:0]       alarm_field_en,
   output logic [5:0]       seconds_count,
   output logic             run
);
   logic [7:0]          irq_en_r;
   logic [7:0]          flag_r;
   logic [4:0]          alen_r;
   logic                subsecond_counter_reset_r;
   logic                one_sec_output_stop_r;
   logic                st_r;
   logic                run_r;
   logic                rd_pend_r;
   rrec_pkg::rrec_sec_t sec_set_r;
   rrec_pkg::rrec_sec_t sec_cnt_r;
   rrec_pkg::rrec_sec_t snap_r;
   rrec_pkg::rrec_rw_e  rw_st;
   logic [1:0]          tally_r;
   logic                pend_r;
   logic                minute_r;
   logic [31:0]         rdata_r;
   logic                half_tick;
   logic                sec_tick;

   // register strobes
   logic ctrl1_wr;
   logic ctrl2_wr;
   logic stat_wr;
   logic mask_wr;
   logic srst_ev;
   logic one_sec_output_stop_nxt;
   logic one_sec_output_stop_rise;
   logic one_sec_output_stop_fall;
   logic st_load;
   logic count_tick;
   logic load_wrap;
   rrec_pkg::rrec_sec_t load_val;
   rrec_pkg::rrec_evt_s evt;
   logic [7:0]          set_v;
   logic [7:0]          clr_v;

   assign ctrl1_wr  = reg_wr && (reg_addr == rrec_pkg::OFS_CTRL1);
   assign ctrl2_wr  = reg_wr && (reg_addr == rrec_pkg::OFS_CTRL2);
   assign stat_wr   = reg_wr && (reg_addr == rrec_pkg::OFS_STAT);
   assign mask_wr   = reg_wr && (reg_addr == rrec_pkg::OFS_MASK);
   assign srst_ev   = ctrl1_wr && reg_wdata[rrec_pkg::SRST_BIT];

   // stop-bit edges seen from the write itself, so no cycle is lost
   assign one_sec_output_stop_nxt  = ctrl1_wr ? reg_wdata[rrec_pkg::ONE_SEC_OUTPUT_STOP_BIT] : one_sec_output_stop_r;
   assign one_sec_output_stop_rise = !one_sec_output_stop_r && one_sec_output_stop_nxt && !srst_ev;
   assign one_sec_output_stop_fall = one_sec_output_stop_r && (!one_sec_output_stop_nxt || srst_ev);
   assign st_load   = st_r && !run_r;

   // one-second clock reaches the counter only outside a rewrite
   assign count_tick = (rw_st == rrec_pkg::RW_COUNT) && run_r && sec_tick;

   // release value: setting, plus one if a carry was saved
   assign load_wrap = pend_r && (sec_set_r == rrec_pkg::SEC_MAX);
   assign load_val  = !pend_r ? sec_set_r :
                      load_wrap ? rrec_pkg::SEC_RST :
                      sec_set_r + 6'h01;

   rrec_tick_gen #(
      .HALF_CYCLES (HALF_CYCLES)
   ) u_tick (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .hold      (!run_r || subsecond_counter_reset_r),
      .half_tick (half_tick),
      .sec_tick  (sec_tick)
   );

   // control bits; soft reset returns them to their reset values
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= rrec_pkg::EVT_RST;
         alen_r   <= rrec_pkg::ALEN_RST;
         subsecond_counter_reset_r  <= 1'b0;
         one_sec_output_stop_r   <= 1'b0;
         st_r     <= 1'b0;
         run_r    <= 1'b0;
      end else if (clk_en) begin
         run_r <= st_r && !srst_ev;
         if (srst_ev) begin
            irq_en_r <= rrec_pkg::EVT_RST;
            alen_r   <= rrec_pkg::ALEN_RST;
            subsecond_counter_reset_r  <= 1'b0;
            one_sec_output_stop_r   <= 1'b0;
            st_r     <= 1'b0;
         end else if (ctrl1_wr) begin
            irq_en_r <= reg_wdata[rrec_pkg::EN_LSB +: 8];
            alen_r   <= reg_wdata[rrec_pkg::ALEN_LSB +: 5];
            subsecond_counter_reset_r  <= reg_wdata[rrec_pkg::SUBSECOND_COUNTER_RESET_BIT];
            one_sec_output_stop_r   <= reg_wdata[rrec_pkg::ONE_SEC_OUTPUT_STOP_BIT];
            st_r     <= reg_wdata[rrec_pkg::ST_BIT];
         end else if (mask_wr) begin
            irq_en_r <= reg_wdata[7:0];
         end
      end
   end

   // seconds setting register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_set_r <= rrec_pkg::SEC_RST;
      end else if (clk_en && reg_wr && (reg_addr == rrec_pkg::OFS_SEC_SET)) begin
         sec_set_r <= reg_wdata[5:0];
      end
   end

   // rewrite sequence: hold while stopped, load once on release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rw_st   <= rrec_pkg::RW_COUNT;
         tally_r <= rrec_pkg::TALLY_RST;
         pend_r  <= 1'b0;
      end else if (clk_en) begin
         unique case (rw_st)
            rrec_pkg::RW_COUNT: begin
               if (one_sec_output_stop_rise) begin
                  rw_st   <= rrec_pkg::RW_HOLD;
                  tally_r <= rrec_pkg::TALLY_RST;
                  pend_r  <= 1'b0;
               end
            end
            rrec_pkg::RW_HOLD: begin
               if (srst_ev) begin
                  rw_st <= rrec_pkg::RW_COUNT;
               end else if (one_sec_output_stop_fall) begin
                  rw_st <= rrec_pkg::RW_LOAD;
               end else begin
                  // tally saturates at the error count
                  if (half_tick && (tally_r != rrec_pkg::TALLY_ERR)) begin
                     tally_r <= tally_r + 2'h1;
                  end
                  if (sec_tick) begin
                     pend_r <= 1'b1;
                  end
               end
            end
            rrec_pkg::RW_LOAD: begin
               if (one_sec_output_stop_rise) begin
                  rw_st   <= rrec_pkg::RW_HOLD;
                  tally_r <= rrec_pkg::TALLY_RST;
                  pend_r  <= 1'b0;
               end else begin
                  rw_st <= rrec_pkg::RW_COUNT;
               end
            end
            default: begin
               rw_st <= rrec_pkg::RW_COUNT;
            end
         endcase
      end
   end

   // seconds counter: not touched by the soft reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt_r <= rrec_pkg::SEC_RST;
         minute_r  <= 1'b0;
      end else if (clk_en) begin
         minute_r <= (count_tick && (sec_cnt_r == rrec_pkg::SEC_MAX)) ||
                     ((rw_st == rrec_pkg::RW_LOAD) && load_wrap);
         if (rw_st == rrec_pkg::RW_LOAD) begin
            sec_cnt_r <= load_val;
         end else if (st_load) begin
            sec_cnt_r <= sec_set_r;
         end else if (count_tick) begin
            sec_cnt_r <= (sec_cnt_r == rrec_pkg::SEC_MAX) ? rrec_pkg::SEC_RST :
                         sec_cnt_r + 6'h01;
         end
      end
   end

   // calendar read: request, then one cycle to copy the counters
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_r <= 1'b0;
         snap_r    <= rrec_pkg::SEC_RST;
      end else if (clk_en) begin
         if (rd_pend_r) begin
            snap_r    <= sec_cnt_r;
            rd_pend_r <= 1'b0;
         end else if (ctrl2_wr && reg_wdata[rrec_pkg::CALENDAR_READ_REQUEST_BIT]) begin
            rd_pend_r <= 1'b1;
         end
      end
   end

   // event sources in register order
   always_comb begin
      evt.read_done   = rd_pend_r;
      evt.rewrite_err = (rw_st == rrec_pkg::RW_LOAD) &&
                        (tally_r == rrec_pkg::TALLY_ERR);
      evt.alarm       = alarm_match_evt;
      evt.timer       = timer_underflow_evt;
      evt.hour        = hour_carry_evt;
      evt.minute      = (count_tick && (sec_cnt_r == rrec_pkg::SEC_MAX)) ||
                        ((rw_st == rrec_pkg::RW_LOAD) && load_wrap);
      evt.second      = count_tick;
      evt.half        = half_tick && run_r;
   end

   // zero clears through the control view, one clears through the status view
   assign set_v = evt;
   assign clr_v = (ctrl1_wr ? ~reg_wdata[rrec_pkg::FLAG_LSB +: 8] : 8'h00) |
                  (stat_wr ? reg_wdata[7:0] : 8'h00);

   // sticky flags; a new event beats a clear in the same cycle
   for (genvar i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            flag_r[i] <= 1'b0;
         end else if (clk_en) begin
            flag_r[i] <= !srst_ev && (set_v[i] || (flag_r[i] && !clr_v[i]));
         end
      end
   end

   // read port, data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0;
      end else if (clk_en) begin
         rdata_r <= 32'h0;
         if (reg_rd) begin
            unique case (reg_addr)
               rrec_pkg::OFS_CTRL1: begin
                  rdata_r <= {irq_en_r,
                              rmw_read ? 8'hff : flag_r,
                              3'h0, alen_r, 1'b0, one_sec_output_stop_r || subsecond_counter_reset_r,
                              subsecond_counter_reset_r, one_sec_output_stop_r, 1'b0, run_r, 1'b0, st_r};
               end
               rrec_pkg::OFS_CTRL2:   rdata_r <= {31'h0, rd_pend_r};
               rrec_pkg::OFS_SEC_SET: rdata_r <= {26'h0, sec_set_r};
               rrec_pkg::OFS_SEC_VAL: rdata_r <= {26'h0, snap_r};
               rrec_pkg::OFS_STAT:    rdata_r <= {24'h0, flag_r};
               rrec_pkg::OFS_MASK:    rdata_r <= {24'h0, irq_en_r};
               default:               rdata_r <= 32'h0;
            endcase
         end
      end
   end

   assign reg_rdata      = rdata_r;
   assign irq            = |(flag_r & irq_en_r);
   assign minute_carry   = minute_r;
   assign alarm_field_en = alen_r;
   assign seconds_count  = sec_cnt_r;
   assign run            = run_r;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_release;
      (rw_st == rrec_pkg::RW_HOLD) && clk_en && one_sec_output_stop_fall && !srst_ev;
   endsequence

   sequence s_load;
      (rw_st == rrec_pkg::RW_LOAD) && clk_en;
   endsequence

   property p_hold_freeze;
      (rw_st == rrec_pkg::RW_HOLD) && clk_en |=> $stable(sec_cnt_r);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("seconds moved while stopped");

   property p_pend_save;
      (rw_st == rrec_pkg::RW_HOLD) && clk_en && sec_tick && !one_sec_output_stop_fall |=> pend_r;
   endproperty
   a_pend_save: assert property (p_pend_save) else $error("carry not saved while stopped");

   property p_load_plus;
      s_release ##1 (s_load and (pend_r && (sec_set_r != rrec_pkg::SEC_MAX)))
         |=> sec_cnt_r == $past(sec_set_r) + 6'h01;
   endproperty
   a_load_plus: assert property (p_load_plus) else $error("release did not add the carry");

   property p_load_plain;
      (s_load and !pend_r) |=> sec_cnt_r == $past(sec_set_r);
   endproperty
   a_load_plain: assert property (p_load_plain) else $error("release added a missing carry");

   property p_err_set;
      // a soft reset in the load cycle wipes the flags, so it is left out
      (s_load and ((tally_r == rrec_pkg::TALLY_ERR) && !srst_ev)) |=> flag_r[6];
   endproperty
   a_err_set: assert property (p_err_set) else $error("rewrite error not flagged");

   property p_err_quiet;
      (s_load and ((tally_r != rrec_pkg::TALLY_ERR) && !flag_r[6])) |=> !flag_r[6];
   endproperty
   a_err_quiet: assert property (p_err_quiet) else $error("rewrite error raised falsely");

   property p_tally_zero;
      (rw_st == rrec_pkg::RW_COUNT) && clk_en && one_sec_output_stop_rise
         |=> (rw_st == rrec_pkg::RW_HOLD) && (tally_r == 2'h0) && !pend_r;
   endproperty
   a_tally_zero: assert property (p_tally_zero) else $error("tally not cleared on stop");

   property p_count_step;
      count_tick && clk_en && (sec_cnt_r != rrec_pkg::SEC_MAX)
         |=> sec_cnt_r == $past(sec_cnt_r) + 6'h01;
   endproperty
   a_count_step: assert property (p_count_step) else $error("seconds failed to count");

   property p_read_done;
      rd_pend_r && clk_en && !srst_ev |=> flag_r[7] && (snap_r == $past(sec_cnt_r));
   endproperty
   a_read_done: assert property (p_read_done) else $error("read copy not completed");

   property p_hour_set;
      hour_carry_evt && clk_en && !srst_ev |=> flag_r[3];
   endproperty
   a_hour_set: assert property (p_hour_set) else $error("hour flag missed");

   property p_timer_set;
      timer_underflow_evt && clk_en && !srst_ev |=> flag_r[4];
   endproperty
   a_timer_set: assert property (p_timer_set) else $error("timer flag missed");

   property p_zero_clear;
      ctrl1_wr && clk_en && !reg_wdata[19] && !hour_carry_evt |=> !flag_r[3];
   endproperty
   a_zero_clear: assert property (p_zero_clear) else $error("zero write kept a flag");

   property p_rmw_ones;
      reg_rd && rmw_read && clk_en && (reg_addr == rrec_pkg::OFS_CTRL1)
         |=> reg_rdata[23:16] == 8'hff;
   endproperty
   a_rmw_ones: assert property (p_rmw_ones) else $error("flags not one in rmw read");

   property p_irq_err;
      flag_r[6] && irq_en_r[6] |-> irq;
   endproperty
   a_irq_err: assert property (p_irq_err) else $error("enabled flag gave no interrupt");
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench of the rtc rewrite-error and first control register block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam logic [7:0] CT = rrec_pkg::OFS_CTRL1;
   localparam logic [7:0] C2 = rrec_pkg::OFS_CTRL2;
   localparam logic [7:0] SS = rrec_pkg::OFS_SEC_SET;
   localparam logic [7:0] SV = rrec_pkg::OFS_SEC_VAL;
   localparam logic [7:0] SA = rrec_pkg::OFS_STAT;
   localparam logic [7:0] MK = rrec_pkg::OFS_MASK;
   localparam int         LIMIT = 3000;

   typedef struct packed {
      logic [7:0]  addr;
      logic        wr;
      logic [31:0] wdata;
      logic [31:0] rexp;
   } rrec_row_s;

   logic        sys_clk             = 1'b0;
   logic        rst_n               = 1'b0;
   logic        clk_en              = 1'b1;
   logic [7:0]  reg_addr            = 8'h00;
   logic [31:0] reg_wdata           = 32'h0000_0000;
   logic        reg_wr              = 1'b0;
   logic        reg_rd              = 1'b0;
   logic        rmw_read            = 1'b0;
   logic [2:0]  evt                 = 3'h0;
   logic [31:0] reg_rdata;
   logic        irq;
   logic        minute_carry;
   logic [4:0]  alarm_field_en;
   logic [5:0]  seconds_count;
   logic        run;
   int          fail_count          = 0;
   int          total_checks        = 0;
   int          cycles              = 0;
   int          mc_cnt              = 0;
   int          mc0;

   // register rows: write (optional) then read back
   rrec_row_s rows [8] = '{
      '{CT, 1'b1, 32'hff00_1f00, 32'hff00_1f00},
      '{CT, 1'b1, 32'h0000_e082, 32'h0000_0000},
      '{SS, 1'b1, 32'h0000_0025, 32'h0000_0025},
      '{MK, 1'b1, 32'h0000_00a5, 32'h0000_00a5},
      '{CT, 1'b0, 32'h0000_0000, 32'ha500_0000},
      '{8'h18, 1'b1, 32'hffff_ffff, 32'h0000_0000},
      '{SV, 1'b1, 32'h0000_003f, 32'h0000_0000},
      '{MK, 1'b1, 32'h0000_0000, 32'h0000_0000}
   };

   rrec_top #(
      .HALF_CYCLES (4)
   ) i_dut (
      .sys_clk             (sys_clk),
      .rst_n               (rst_n),
      .clk_en              (clk_en),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .rmw_read            (rmw_read),
      .alarm_match_evt     (evt[2]),
      .timer_underflow_evt (evt[1]),
      .hour_carry_evt      (evt[0]),
      .reg_rdata           (reg_rdata),
      .irq                 (irq),
      .minute_carry        (minute_carry),
      .alarm_field_en      (alarm_field_en),
      .seconds_count       (seconds_count),
      .run                 (run)
   );

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   // cycle ceiling cuts a hang short; minute carries are tallied
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (minute_carry === 1'b1) mc_cnt <= mc_cnt + 1;
      if (cycles == LIMIT) begin
         fail_count++;
         $display("unexpected at %0t: run too long", $time);
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic m, input logic [31:0] mk,
                      input logic [31:0] e);
      logic [31:0] d;
      reg_addr <= a;
      reg_rd   <= 1'b1;
      rmw_read <= m;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      rmw_read <= 1'b0;
      #1 d = reg_rdata;
      chk(d & mk, e);
      @(posedge sys_clk);
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      // the initial low level makes no edge, so look only once clock edges have passed
      repeat (8) @(posedge sys_clk);
      chk({18'h0, irq, run, minute_carry, alarm_field_en, seconds_count}, 32'h0);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk({18'h0, irq, run, minute_carry, alarm_field_en, seconds_count}, 32'h0);
   endtask

   // returns on the rising edge one cycle after the edge on which seconds moved
   task automatic wait_tick();
      rrec_pkg::rrec_sec_t s;
      s = seconds_count;
      for (int i = 0; i < 20 && seconds_count === s; i++) @(negedge sys_clk);
      @(posedge sys_clk);
   endtask

   // hold the seconds for a timed window aligned to a second tick, then release
   task automatic rewrite(input logic [5:0] set, input int n, input logic [5:0] e,
                          input logic err);
      rrec_pkg::rrec_sec_t s0;
      wr(SS, {26'h0, set});
      wait_tick();
      s0 = seconds_count;
      wr(CT, 32'h0000_0011);
      if (n > 0) rdc(CT, 1'b0, 32'h0000_00ff, 32'h0000_0055);
      repeat (n) @(posedge sys_clk);
      chk({26'h0, seconds_count}, {26'h0, s0});
      wr(CT, 32'h00ff_0001);
      // the load lands on the edge at which the write task returns
      @(negedge sys_clk);
      chk({26'h0, seconds_count}, {26'h0, e});
      @(posedge sys_clk);
      rdc(CT, 1'b0, 32'h0040_0000, {9'h0, err, 22'h0});
   endtask

   initial begin
      do_reset();
      rdc(CT, 1'b0, 32'hffff_ffff, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
         rdc(rows[i].addr, 1'b0, 32'hffff_ffff, rows[i].rexp);
      end
      wr(CT, 32'h0000_1f00);
      #1 chk({27'h0, alarm_field_en}, 32'h0000_001f);
      @(posedge sys_clk);
      // strobes are ignored while the clock enable is low
      clk_en <= 1'b0;
      wr(MK, 32'h0000_00ff);
      clk_en <= 1'b1;
      rdc(MK, 1'b0, 32'hffff_ffff, 32'h0000_0000);
      // event flags, interrupt level and both ways of clearing
      wr(C2, 32'h0000_0001);
      evt <= 3'h7;
      @(posedge sys_clk);
      evt <= 3'h0;
      @(posedge sys_clk);
      rdc(CT, 1'b0, 32'hffff_ffff, 32'h00b8_1f00);
      chk({31'h0, irq}, 32'h0);
      wr(MK, 32'h0000_0008);
      #1 chk({31'h0, irq}, 32'h1);
      @(posedge sys_clk);
      rdc(CT, 1'b1, 32'hffff_ffff, 32'h08ff_1f00);
      wr(CT, 32'h08f7_0000);
      #1 chk({31'h0, irq}, 32'h0);
      @(posedge sys_clk);
      rdc(CT, 1'b0, 32'hffff_ffff, 32'h08b0_0000);
      wr(SA, 32'h0000_00b0);
      rdc(SA, 1'b0, 32'hffff_ffff, 32'h0000_0000);
      wr(MK, 32'h0000_0000);
      // start counting from the seconds setting
      wr(SS, 32'h0000_0006);
      wr(CT, 32'h0000_0001);
      @(posedge sys_clk);
      #1 chk({25'h0, run, seconds_count}, {26'h1, 6'd6});
      wait_tick();
      chk({26'h0, seconds_count}, 32'd7);
      // long hold: four second carries, one kept, error raised
      rewrite(6'd50, 28, 6'd51, 1'b1);
      wr(MK, 32'h0000_0040);
      #1 chk({31'h0, irq}, 32'h1);
      @(posedge sys_clk);
      // rewrite repeated after the error, no carry inside the hold
      rewrite(6'd20, 0, 6'd20, 1'b0);
      chk({31'h0, irq}, 32'h0);
      // two half carries and one second carry, wrapping into the minute
      mc0 = mc_cnt;
      rewrite(6'd59, 4, 6'd0, 1'b0);
      chk(32'(mc_cnt - mc0), 32'h1);
      // soft reset clears control state but keeps seconds
      wr(CT, 32'h0000_0008);
      rdc(CT, 1'b0, 32'hffff_ffff, 32'h0000_0000);
      #1 chk({31'h0, run}, 32'h0);
      @(posedge sys_clk);
      // asynchronous reset in mid-run
      wr(CT, 32'h0000_0001);
      do_reset();
      rdc(CT, 1'b0, 32'hffff_ffff, 32'h0000_0000);
      stop_test();
   end
endmodule
`default_nettype wire
